// ===== logic/clb_bus_if.sv
`timescale 1ns/1ps
interface clb_bus_if;
    import clb_pkg::*;
    logic address_strobe_n;
    logic mem_or_io_select;
    logic data_or_code_select;
    logic write_or_read_select;
    logic [3:0] byte_lane_enable_n;
    logic byte_lane_enable_oe;
    logic [29:0] word_address_out;
    logic word_address_oe;
    logic [27:0] inval_address_in;
    logic inval_address_oe;
    logic inval_strobe;
    logic [31:0] data_dev_out;
    logic data_dev_oe;
    logic [31:0] data_ext_out;
    logic data_ext_oe;
    logic ready_n;
    logic bus_hold;
    logic addr_hold;
    modport dev (
        output address_strobe_n, mem_or_io_select, data_or_code_select,
        output write_or_read_select, byte_lane_enable_n,
        output byte_lane_enable_oe, word_address_out, word_address_oe,
        output data_dev_out, data_dev_oe,
        input inval_address_in, inval_address_oe, inval_strobe,
        input data_ext_out, data_ext_oe, ready_n, bus_hold, addr_hold
    );
    modport ext (
        input address_strobe_n, mem_or_io_select, data_or_code_select,
        input write_or_read_select, byte_lane_enable_n,
        input byte_lane_enable_oe, word_address_out, word_address_oe,
        input data_dev_out, data_dev_oe,
        output inval_address_in, inval_address_oe, inval_strobe,
        output data_ext_out, data_ext_oe, ready_n, bus_hold, addr_hold
    );
endinterface

// ===== logic/clb_dev.sv
`timescale 1ns/1ps
// Behaviour
// - everything on rising clk_sys_i edge
// - word address plus byte enables locate access
// - address undriven during bus/address hold, between cycles only
// - external drives upper address for invalidation
// - first cache fill transfer: all lanes
// - byte enables low active, undriven in hold between cycles
// - enable n governs data byte n
// - bits 7:0 least, 31:24 most significant
// - write data driven from second clock on
// - cycle definition valid with address strobe
// - three lines encode type, zero is inta
module clb_dev
    import clb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    clb_bus_if.dev bus,
    input wire logic req_i,
    input wire logic [2:0] req_cycle_i,
    input wire logic [29:0] req_addr_i,
    input wire logic [3:0] req_be_n_i,
    input wire logic req_fill_i,
    input wire logic [31:0] req_wdata_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [31:0] rdata_o,
    output logic inval_valid_o,
    output logic [27:0] inval_addr_o
);
    clb_state_t state_ff, nxt_state;
    logic [2:0] cyc_ff, nxt_cyc;
    logic [29:0] addr_ff, nxt_addr;
    logic [3:0] be_ff, nxt_be;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [31:0] rdata_ff, nxt_rdata;
    logic done_ff, nxt_done;
    logic inval_ff, nxt_inval;
    logic [27:0] inval_addr_ff, nxt_inval_addr;
    logic [2:0] hold_sync_ff, nxt_hold_sync;
    logic hold_q_ff, nxt_hold_q;
    logic active;
    logic is_write;
    logic take_req;
    logic end_cyc;
    logic [3:0] lane_take;

    // special cycles carry the write bit yet move no data
    function automatic logic writes_data(input logic [2:0] cyc);
        writes_data = cyc[0] && (cyc != CLB_CYC_SPECIAL);
    endfunction

    assign is_write = writes_data(cyc_ff);
    assign active = (state_ff != CLB_IDLE);
    assign req_ready_o = (state_ff == CLB_IDLE) && !hold_q_ff;
    assign take_req = req_i && req_ready_o;
    assign end_cyc = (state_ff == CLB_DATA) && !bus.ready_n;

    // a lane is read only while enabled and driven by the far end
    for (genvar g = 0; g < CLB_BW; g++) begin : g_lane
        assign lane_take[g] = !be_ff[g] && !is_write && bus.data_ext_oe;
    end

    // hold pins are asynchronous to us: three stages, second and third agree
    always_comb begin
        nxt_hold_sync = {hold_sync_ff[1:0], bus.bus_hold | bus.addr_hold};
        nxt_hold_q = hold_q_ff;
        if (hold_sync_ff[2] == hold_sync_ff[1]) begin
            nxt_hold_q = hold_sync_ff[2];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_sync_ff <= CLB_SYNC_RST;
            hold_q_ff <= 1'b0;
        end else begin
            hold_sync_ff <= nxt_hold_sync;
            hold_q_ff <= nxt_hold_q;
        end
    end

    // address, enables and type reload only between cycles
    always_comb begin
        nxt_cyc = cyc_ff;
        nxt_addr = addr_ff;
        nxt_be = be_ff;
        nxt_wdata = wdata_ff;
        if (take_req) begin
            nxt_cyc = req_cycle_i;
            nxt_addr = req_addr_i;
            // far end treats a fill's first transfer as all lanes
            nxt_be = req_fill_i ? CLB_BE_ALL : req_be_n_i;
            // reads keep the old word: no needless toggling
            if (writes_data(req_cycle_i)) begin
                nxt_wdata = req_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_ff <= CLB_CYC_RST;
            addr_ff <= CLB_ADDR_RST;
            be_ff <= CLB_BE_RST;
            wdata_ff <= CLB_DATA_RST;
        end else begin
            cyc_ff <= nxt_cyc;
            addr_ff <= nxt_addr;
            be_ff <= nxt_be;
            wdata_ff <= nxt_wdata;
        end
    end

    // one address clock, then data clocks until ready
    always_comb begin
        nxt_state = state_ff;
        nxt_done = 1'b0;
        unique case (state_ff)
            CLB_IDLE: begin
                if (take_req) begin
                    nxt_state = CLB_ADDR;
                end
            end
            CLB_ADDR: begin
                nxt_state = CLB_DATA;
            end
            CLB_DATA: begin
                // address, enables and type stay put until ready
                if (end_cyc) begin
                    nxt_state = CLB_IDLE;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_state = CLB_IDLE;
            end
        endcase
    end

    // done_o pulses for the one clock after ready is seen
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= CLB_IDLE;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            done_ff <= nxt_done;
        end
    end

    // lanes copied only in the clock that ends a read
    always_comb begin
        nxt_rdata = rdata_ff;
        if (end_cyc) begin
            for (int i = 0; i < CLB_BW; i++) begin
                if (lane_take[i]) begin
                    nxt_rdata[8*i +: 8] = bus.data_ext_out[8*i +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= CLB_DATA_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // invalidation address taken when external logic strobes it
    always_comb begin
        nxt_inval = 1'b0;
        nxt_inval_addr = inval_addr_ff;
        if (bus.inval_strobe && bus.inval_address_oe
                && !bus.word_address_oe) begin
            nxt_inval = 1'b1;
            nxt_inval_addr = bus.inval_address_in;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inval_ff <= 1'b0;
            inval_addr_ff <= CLB_INV_ADDR_RST;
        end else begin
            inval_ff <= nxt_inval;
            inval_addr_ff <= nxt_inval_addr;
        end
    end

    assign bus.address_strobe_n = !(state_ff == CLB_ADDR);
    assign bus.mem_or_io_select = cyc_ff[2];
    assign bus.data_or_code_select = cyc_ff[1];
    assign bus.write_or_read_select = cyc_ff[0];
    assign bus.word_address_out = addr_ff;
    // hold only honoured between cycles, so a cycle is never torn
    assign bus.word_address_oe = active || !hold_q_ff;
    assign bus.byte_lane_enable_n = be_ff;
    assign bus.byte_lane_enable_oe = active || !hold_q_ff;
    assign bus.data_dev_out = wdata_ff;
    assign bus.data_dev_oe = (state_ff == CLB_DATA) && is_write;
    assign done_o = done_ff;
    assign rdata_o = rdata_ff;
    assign inval_valid_o = inval_ff;
    assign inval_addr_o = inval_addr_ff;
endmodule

// ===== logic/clb_ext.sv
`timescale 1ns/1ps
module clb_ext
    import clb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    clb_bus_if.ext bus,
    input wire logic bus_hold_i,
    input wire logic addr_hold_i,
    input wire logic ack_i,
    input wire logic [31:0] rd_data_i,
    input wire logic inval_i,
    input wire logic [27:0] inval_addr_i,
    output logic cyc_valid_o,
    output logic [2:0] cyc_type_o,
    output logic [29:0] cyc_addr_o,
    output logic [3:0] cyc_lanes_o,
    output logic [31:0] cyc_wdata_o,
    output logic cyc_wdata_valid_o
);
    logic in_cyc_ff, nxt_in_cyc;
    logic [2:0] type_ff, nxt_type;
    logic [29:0] addr_ff, nxt_addr;
    logic [3:0] lanes_ff, nxt_lanes;
    logic [31:0] wdata_ff, nxt_wdata;
    logic wvalid_ff, nxt_wvalid;
    logic [31:0] rd_ff, nxt_rd;
    logic rdy_ff, nxt_rdy;
    logic [27:0] inval_addr_ff, nxt_inval_addr;
    logic inval_ff, nxt_inval;

    always_comb begin
        nxt_in_cyc = in_cyc_ff;
        nxt_type = type_ff;
        nxt_addr = addr_ff;
        nxt_lanes = lanes_ff;
        nxt_wdata = wdata_ff;
        nxt_wvalid = 1'b0;
        nxt_rd = rd_ff;
        nxt_rdy = 1'b0;
        // a strobe in the ending clock must still open the next cycle
        if (rdy_ff) begin
            nxt_in_cyc = 1'b0;
        end
        if (!bus.address_strobe_n) begin
            nxt_in_cyc = 1'b1;
            nxt_type = {bus.mem_or_io_select, bus.data_or_code_select,
                        bus.write_or_read_select};
            nxt_addr = bus.word_address_out;
            nxt_lanes = ~bus.byte_lane_enable_n;
        end
        if (in_cyc_ff && bus.data_dev_oe) begin
            nxt_wdata = bus.data_dev_out;
            nxt_wvalid = 1'b1;
        end
        if (in_cyc_ff && ack_i && !rdy_ff) begin
            nxt_rdy = 1'b1;
            nxt_rd = rd_data_i;
        end
    end

    always_comb begin
        nxt_inval = inval_i && addr_hold_i;
        nxt_inval_addr = inval_i ? inval_addr_i : inval_addr_ff;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_cyc_ff <= 1'b0;
            type_ff <= CLB_CYC_RST;
            addr_ff <= CLB_ADDR_RST;
            lanes_ff <= CLB_LANES_RST;
            wdata_ff <= CLB_DATA_RST;
            wvalid_ff <= 1'b0;
            rd_ff <= CLB_DATA_RST;
            rdy_ff <= 1'b0;
            inval_addr_ff <= CLB_INV_ADDR_RST;
            inval_ff <= 1'b0;
        end else begin
            in_cyc_ff <= nxt_in_cyc;
            type_ff <= nxt_type;
            addr_ff <= nxt_addr;
            lanes_ff <= nxt_lanes;
            wdata_ff <= nxt_wdata;
            wvalid_ff <= nxt_wvalid;
            rd_ff <= nxt_rd;
            rdy_ff <= nxt_rdy;
            inval_addr_ff <= nxt_inval_addr;
            inval_ff <= nxt_inval;
        end
    end

    assign bus.ready_n = !rdy_ff;
    assign bus.data_ext_out = rd_ff;
    assign bus.data_ext_oe = rdy_ff && !type_ff[0];
    assign bus.bus_hold = bus_hold_i;
    assign bus.addr_hold = addr_hold_i;
    // invalidation address only driven while the device floats its own
    assign bus.inval_address_in = inval_addr_ff;
    assign bus.inval_address_oe = inval_ff && !bus.word_address_oe;
    assign bus.inval_strobe = inval_ff;
    assign cyc_valid_o = in_cyc_ff;
    assign cyc_type_o = type_ff;
    assign cyc_addr_o = addr_ff;
    assign cyc_lanes_o = lanes_ff;
    assign cyc_wdata_o = wdata_ff;
    assign cyc_wdata_valid_o = wvalid_ff;
endmodule

// ===== logic/clb_pkg.sv
package clb_pkg;
    localparam int CLB_AW = 30;
    localparam int CLB_DW = 32;
    localparam int CLB_BW = 4;
    localparam int CLB_INV_LO = 2;
    localparam logic [2:0] CLB_CYC_INTA = 3'h0;
    localparam logic [2:0] CLB_CYC_IO_RD = 3'h2;
    localparam logic [2:0] CLB_CYC_IO_WR = 3'h3;
    localparam logic [2:0] CLB_CYC_CODE_RD = 3'h4;
    localparam logic [2:0] CLB_CYC_MEM_RD = 3'h6;
    localparam logic [2:0] CLB_CYC_MEM_WR = 3'h7;
    localparam logic [2:0] CLB_CYC_RST = 3'h6;
    localparam logic [3:0] CLB_BE_RST = 4'hF;
    localparam logic [3:0] CLB_BE_ALL = 4'h0;
    localparam logic [2:0] CLB_CYC_SPECIAL = 3'h1;
    localparam logic [3:0] CLB_LANES_RST = 4'h0;
    localparam logic [27:0] CLB_INV_ADDR_RST = 28'h0;
    localparam logic [2:0] CLB_SYNC_RST = 3'h0;
    localparam logic [29:0] CLB_ADDR_RST = 30'h0;
    localparam logic [31:0] CLB_DATA_RST = 32'h0;
    typedef enum logic [1:0] {
        CLB_IDLE,
        CLB_ADDR,
        CLB_DATA
    } clb_state_t;
endpackage

// ===== tb/clb_bus_properties.sv
`timescale 1ns/1ps
module clb_bus_properties (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic address_strobe_n,
    input wire logic mem_or_io_select,
    input wire logic data_or_code_select,
    input wire logic write_or_read_select,
    input wire logic [3:0] byte_lane_enable_n,
    input wire logic byte_lane_enable_oe,
    input wire logic [29:0] word_address_out,
    input wire logic word_address_oe,
    input wire logic data_dev_oe,
    input wire logic ready_n,
    input wire logic bus_hold,
    input wire logic addr_hold
);
    logic in_cyc_ff;
    logic nxt_in_cyc;
    logic [36:0] cyc_def;
    assign cyc_def = {mem_or_io_select, data_or_code_select,
        write_or_read_select, byte_lane_enable_n, word_address_out};
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    // ready_n outside a cycle is ignored, so only a strobe opens one
    always_comb begin
        nxt_in_cyc = in_cyc_ff;
        if (!address_strobe_n) begin
            nxt_in_cyc = 1'b1;
        end else if (!ready_n) begin
            nxt_in_cyc = 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_cyc_ff <= 1'b0;
        end else begin
            in_cyc_ff <= nxt_in_cyc;
        end
    end
    // special cycles carry the write bit but move no data
    sequence wr_start;
        !address_strobe_n && write_or_read_select
            && (mem_or_io_select || data_or_code_select);
    endsequence
    AST_STROBE_ONE: assert property (
        !address_strobe_n |=> address_strobe_n)
        else $error("strobe low for more than one cycle");
    AST_CYC_STABLE: assert property (in_cyc_ff |-> $stable(cyc_def))
        else $error("cycle definition moved inside a cycle");
    AST_NO_RESTROBE: assert property (in_cyc_ff |-> address_strobe_n)
        else $error("strobe repeated inside a cycle");
    AST_WR_FIRST: assert property (
        wr_start |-> !data_dev_oe ##1 data_dev_oe)
        else $error("write data not driven from second clock only");
    AST_WR_LATER: assert property (
        in_cyc_ff && write_or_read_select
            && (mem_or_io_select || data_or_code_select) |-> data_dev_oe)
        else $error("write data released inside the cycle");
    AST_RD_FLOAT: assert property (
        in_cyc_ff && !write_or_read_select |-> !data_dev_oe)
        else $error("data driven during a read");
    AST_STROBE_DRIVEN: assert property (
        !address_strobe_n |-> word_address_oe && byte_lane_enable_oe)
        else $error("address or lanes floating at strobe");
    AST_BUS_HOLD: assert property (
        bus_hold [*8] ##0 (!in_cyc_ff && address_strobe_n)
            |=> !word_address_oe && !byte_lane_enable_oe)
        else $error("address or lanes driven in bus hold");
    AST_ADDR_HOLD: assert property (
        addr_hold [*8] ##0 (!in_cyc_ff && address_strobe_n)
            |=> !word_address_oe)
        else $error("address driven in address hold");
endmodule

// ===== tb/clb_tb.sv
`timescale 1ns/1ps
module clb_tb;
    import clb_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_i = 1'b0;
    logic [2:0] req_cycle_i = CLB_CYC_MEM_RD;
    logic [29:0] req_addr_i = CLB_ADDR_RST;
    logic [3:0] req_be_n_i = CLB_BE_RST;
    logic req_fill_i = 1'b0;
    logic [31:0] req_wdata_i = CLB_DATA_RST;
    logic bus_hold_i = 1'b0;
    logic addr_hold_i = 1'b0;
    logic ack_i = 1'b0;
    logic [31:0] rd_data_i = CLB_DATA_RST;
    logic inval_i = 1'b0;
    logic [27:0] inval_addr_i = 28'h0;
    logic req_ready_o, done_o, inval_valid_o, cyc_valid_o, cyc_wdata_valid_o;
    logic [31:0] rdata_o, cyc_wdata_o;
    logic [31:0] exp_rd = CLB_DATA_RST;
    logic [27:0] inval_addr_o;
    logic [2:0] cyc_type_o;
    logic [29:0] cyc_addr_o;
    logic [3:0] cyc_lanes_o;
    int err_total = 0;
    int num_checks = 0;
    clb_bus_if bus ();
    clb_dev clb_dev_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .bus(bus.dev), .req_i(req_i), .req_cycle_i(req_cycle_i),
        .req_addr_i(req_addr_i), .req_be_n_i(req_be_n_i),
        .req_fill_i(req_fill_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .inval_valid_o(inval_valid_o), .inval_addr_o(inval_addr_o));
    clb_ext clb_ext_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .bus(bus.ext), .bus_hold_i(bus_hold_i), .addr_hold_i(addr_hold_i),
        .ack_i(ack_i), .rd_data_i(rd_data_i), .inval_i(inval_i),
        .inval_addr_i(inval_addr_i), .cyc_valid_o(cyc_valid_o),
        .cyc_type_o(cyc_type_o), .cyc_addr_o(cyc_addr_o),
        .cyc_lanes_o(cyc_lanes_o), .cyc_wdata_o(cyc_wdata_o),
        .cyc_wdata_valid_o(cyc_wdata_valid_o));
    clb_bus_properties clb_bus_properties_i (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .address_strobe_n(bus.address_strobe_n),
        .mem_or_io_select(bus.mem_or_io_select),
        .data_or_code_select(bus.data_or_code_select),
        .write_or_read_select(bus.write_or_read_select),
        .byte_lane_enable_n(bus.byte_lane_enable_n),
        .byte_lane_enable_oe(bus.byte_lane_enable_oe),
        .word_address_out(bus.word_address_out),
        .word_address_oe(bus.word_address_oe),
        .data_dev_oe(bus.data_dev_oe), .ready_n(bus.ready_n),
        .bus_hold(bus.bus_hold), .addr_hold(bus.addr_hold));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // one whole cycle; dly stretches the acknowledge to test slow ends
    task automatic xfer(input logic [2:0] cy, input logic [29:0] a,
            input logic [3:0] be, input logic fl, input int dly);
        logic [3:0] ln;
        logic seen;
        int k;
        ln = fl ? CLB_BE_ALL : be;
        seen = 1'b0;
        k = 0;
        while (req_ready_o !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        chk("ready", 32'h1, {31'h0, req_ready_o});
        req_i = 1'b1;
        req_cycle_i = cy;
        req_addr_i = a;
        req_be_n_i = be;
        req_fill_i = fl;
        req_wdata_i = 32'h5E6F7081 ^ {2'h0, a};
        rd_data_i = 32'hA1B2C3D4 ^ {a, 2'h0};
        tick(1);
        req_i = 1'b0;
        k = 0;
        while (done_o !== 1'b1 && k < 30) begin
            tick(1);
            k++;
            ack_i = (k > dly) && (done_o !== 1'b1);
            if (cyc_valid_o === 1'b1 && !seen) begin
                seen = 1'b1;
                chk("type", {29'h0, cy}, {29'h0, cyc_type_o});
                chk("addr", {2'h0, a}, {2'h0, cyc_addr_o});
                chk("lanes", {28'h0, ~ln}, {28'h0, cyc_lanes_o});
            end
            if (cyc_wdata_valid_o === 1'b1) begin
                chk("wdata", req_wdata_i, cyc_wdata_o);
            end
        end
        chk("done", 32'h1, {31'h0, done_o});
        chk("seen", 32'h1, {31'h0, seen});
        for (int i = 0; i < 4; i++) begin
            if (!cy[0] && !ln[i]) begin
                exp_rd[8*i +: 8] = rd_data_i[8*i +: 8];
            end
        end
        chk("rdata", exp_rd, rdata_o);
    endtask
    initial begin
        tick(10);
        rst_n_i = 1'b1;
        tick(1);
        chk("be rst", {28'h0, CLB_BE_RST},
            {28'h0, bus.byte_lane_enable_n});
        for (int i = 0; i < 7; i++) begin
            xfer(i == 0 ? CLB_CYC_INTA : i == 1 ? CLB_CYC_IO_RD :
                i == 2 ? CLB_CYC_IO_WR : i == 3 ? CLB_CYC_CODE_RD :
                i == 4 ? CLB_CYC_MEM_RD : CLB_CYC_MEM_WR,
                30'h3FFFFFFF >> (4 * i), 4'(4'hE << i), 1'b0, i % 3);
        end
        $display("test cycle types done");
        xfer(CLB_CYC_MEM_RD, 30'h40, 4'hE, 1'b1, 0);
        $display("test fill done");
        bus_hold_i = 1'b1;
        tick(10);
        chk("addr oe hold", 32'h0, {31'h0, bus.word_address_oe});
        chk("be oe hold", 32'h0, {31'h0, bus.byte_lane_enable_oe});
        chk("ready hold", 32'h0, {31'h0, req_ready_o});
        bus_hold_i = 1'b0;
        addr_hold_i = 1'b1;
        tick(10);
        chk("addr oe ahold", 32'h0, {31'h0, bus.word_address_oe});
        inval_i = 1'b1;
        inval_addr_i = 28'hABCDEF1;
        tick(1);
        inval_i = 1'b0;
        for (int k = 0; k < 10 && inval_valid_o !== 1'b1; k++) begin
            tick(1);
        end
        chk("inval valid", 32'h1, {31'h0, inval_valid_o});
        chk("inval", 32'h0ABCDEF1, {4'h0, inval_addr_o});
        addr_hold_i = 1'b0;
        tick(6);
        xfer(CLB_CYC_MEM_WR, 30'h0, 4'h0, 1'b0, 1);
        $display("test hold and invalidation done");
        print_verdict();
    end
    initial begin
        #(40 * 3000);
        err_total++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
